// ==== ues_status_bank.sv ====
// capability header, uncorrectable status and mask registers of one switch port
// Functional notes
// - header bits 15:0 read capability id 1
// - header bits 19:16 read version 1
// - next pointer writable only while unlocked
// - obsolete bit 0 never set by hardware
// - bit 4 sets on link protocol error
// - bit 5 needs surprise down and capability
// - bit 12 sets on poisoned packet
// - bit 13 sets on flow control error
// - bit 14 always reads zero
// - bit 15 zero; abort logs as violation
// - bit 16 sets on unexpected completion
// - bit 17 sets on receive overflow
// - bit 18 sets on malformed packet
// - bit 19 sets on end-to-end CRC failure
// - bit 20 sets on unsupported request
// - bit 21 sets on access control violation
// - bit 22 sets on port internal error
// - bit 23 sets on blocked multicast packet while either multicast block control is on
// - mask stops reporting, never status setting
`timescale 1ns/1ps
module ues_status_bank
  import ues_pkg::*;
#(
  parameter logic [11:0] NXT_PTR_DEFAULT = UES_NEXT_CAPABILITY_POINTER_RST
)
(
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic                  hotRst_n,
  input  wire logic [UES_ADDR_W-1:0] regAddr,
  input  wire logic [UES_DATA_W-1:0] regWrData,
  input  wire logic                  regWr,
  input  wire logic                  regRd,
  output logic      [UES_DATA_W-1:0] regRdData_ff,
  input  wire logic                  cfgLocked,
  input  wire logic                  surpriseDownReportCapable,
  input  wire logic                  multicastBlockEvery,
  input  wire logic                  multicastBlockRawAddr,
  input  wire logic                  linkProtocolErrDet,
  input  wire logic                  surpriseDownDet,
  input  wire logic                  poisonedDet,
  input  wire logic                  flowCtrlErrDet,
  input  wire logic                  unexpCplDet,
  input  wire logic                  rxOverflowDet,
  input  wire logic                  malformedDet,
  input  wire logic                  ecrcErrDet,
  input  wire logic                  unsupReqDet,
  input  wire logic                  acsViolDet,
  input  wire logic                  cplAbortForAcs,
  input  wire logic                  internalErrDet,
  input  wire logic                  mcastBlockedDet,
  output logic                       errReport_ff,
  output logic                       firstErrValid_ff,
  output logic      [UES_PTR_W-1:0]  firstErrPtr_ff,
  output logic      [UES_DATA_W-1:0] uncorStatus_ff
);

  logic [UES_DATA_W-1:0] evtVec;
  logic [UES_DATA_W-1:0] clrVec;
  logic [UES_DATA_W-1:0] stsVec;
  logic [UES_DATA_W-1:0] maskVec_ff;
  logic [UES_DATA_W-1:0] unmaskedEvt;
  logic [11:0]           next_capability_pointer_ff;
  logic                  capSel;
  logic                  stsSel;
  logic                  mskSel;
  logic                  stsWr;
  logic [UES_DATA_W-1:0] nxt_rdData;
  logic                  nxt_errReport;
  logic                  nxt_fepValid;
  logic [UES_PTR_W-1:0]  nxt_fepPtr;

  // lowest set bit index of an error vector
  function automatic logic [UES_PTR_W-1:0] lowestIdx(input logic [UES_DATA_W-1:0] vec);
    logic [UES_PTR_W-1:0] idx;
    idx = '0;
    for (int i = UES_DATA_W - 1; i >= 0; i--)
    begin
      if (vec[i])
        idx = UES_PTR_W'(i);
    end
    return idx;
  endfunction : lowestIdx

  // address decode
  always_comb
  begin
    capSel = (regAddr == UES_OFF_CAP_HDR);
    stsSel = (regAddr == UES_OFF_STATUS);
    mskSel = (regAddr == UES_OFF_MASK);
    stsWr  = regWr & stsSel;
  end

  // detection events mapped onto status positions
  always_comb
  begin
    evtVec                  = '0;
    evtVec[UES_B_OBSOLETE]  = 1'b0;
    evtVec[UES_B_LINK_PROT] = linkProtocolErrDet;
    evtVec[UES_B_SURP_DOWN] = surpriseDownDet & surpriseDownReportCapable;
    evtVec[UES_B_POISONED]  = poisonedDet;
    evtVec[UES_B_FLOW_CTRL] = flowCtrlErrDet;
    evtVec[UES_B_CPL_TMO]   = 1'b0;
    evtVec[UES_B_CPL_ABORT] = 1'b0;
    evtVec[UES_B_UNEXP_CPL] = unexpCplDet;
    evtVec[UES_B_RX_OVFL]   = rxOverflowDet;
    evtVec[UES_B_MALFORMED] = malformedDet;
    evtVec[UES_B_ECRC]      = ecrcErrDet;
    evtVec[UES_B_UNSUP_REQ] = unsupReqDet;
    evtVec[UES_B_ACS_VIOL]  = acsViolDet | cplAbortForAcs;
    evtVec[UES_B_INT_ERR]   = internalErrDet;
    evtVec[UES_B_MC_BLOCK]  = mcastBlockedDet & (multicastBlockEvery | multicastBlockRawAddr);
  end

  // write-one-to-clear requests, only on implemented bits
  always_comb
  begin
    clrVec = stsWr ? (regWrData & UES_STS_IMPL) : '0;
  end

  // one sticky cell per implemented status bit; others tie low
  for (genvar gi = 0; gi < UES_DATA_W; gi++)
  begin : g_sts
    if (UES_STS_IMPL[gi])
    begin : g_cell
      ues_sticky_cell u_cell (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .setEvt  (evtVec[gi]),
        .clrReq  (clrVec[gi]),
        .flag_ff (stsVec[gi])
      );
    end
    else
    begin : g_rsvd
      assign stsVec[gi] = 1'b0;
    end
  end

  // mask does not gate the status cells, only the report path
  always_comb
  begin
    unmaskedEvt = evtVec & ~maskVec_ff;
  end

  // mask register, sticky
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      maskVec_ff <= UES_MASK_RST;
    else if (regWr && mskSel)
      maskVec_ff <= regWrData & UES_STS_IMPL;
  end

  // next capability pointer, locked writes ignored, not sticky
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || !hotRst_n)
      next_capability_pointer_ff <= NXT_PTR_DEFAULT;
    else if (regWr && capSel && !cfgLocked)
      next_capability_pointer_ff <= regWrData[UES_NEXT_CAPABILITY_POINTER_LSB +: 12];
  end

  // read data mux, unmapped reads return zero
  always_comb
  begin
    nxt_rdData = '0;
    if (regRd)
    begin
      if (capSel)
      begin
        nxt_rdData[UES_CAPABILITY_IDENTIFIER_LSB +: 16]  = UES_CAPABILITY_IDENTIFIER_VAL;
        nxt_rdData[UES_CAPABILITY_VERSION_FIELD_LSB +: 4]  = UES_CAPABILITY_VERSION_FIELD_VAL;
        nxt_rdData[UES_NEXT_CAPABILITY_POINTER_LSB +: 12] = next_capability_pointer_ff;
      end
      else if (stsSel)
        nxt_rdData = stsVec & UES_STS_IMPL;
      else if (mskSel)
        nxt_rdData = maskVec_ff;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      regRdData_ff <= '0;
    else
      regRdData_ff <= nxt_rdData;
  end

  // report pulse for any unmasked detection
  always_comb
  begin
    nxt_errReport = |unmaskedEvt;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || !hotRst_n)
      errReport_ff <= 1'b0;
    else
      errReport_ff <= nxt_errReport;
  end

  // first error pointer: freed when its status bit clears, masked errors skip it
  always_comb
  begin
    nxt_fepValid = firstErrValid_ff;
    nxt_fepPtr   = firstErrPtr_ff;
    if (firstErrValid_ff && clrVec[firstErrPtr_ff] && !evtVec[firstErrPtr_ff])
      nxt_fepValid = 1'b0;
    else if (!firstErrValid_ff && (|unmaskedEvt))
    begin
      nxt_fepValid = 1'b1;
      nxt_fepPtr   = lowestIdx(unmaskedEvt);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      firstErrValid_ff <= 1'b0;
      firstErrPtr_ff   <= '0;
    end
    else
    begin
      firstErrValid_ff <= nxt_fepValid;
      firstErrPtr_ff   <= nxt_fepPtr;
    end
  end

  // status copy for the port's reporting logic
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      uncorStatus_ff <= UES_STS_RST;
    else
      uncorStatus_ff <= stsVec;
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  cap_id_read_a: assert property (
    regRd && capSel |=> regRdData_ff[15:0] == 16'h0001)
    else $error("capability id wrong");

  cap_ver_read_a: assert property (
    regRd && capSel |=> regRdData_ff[19:16] == 4'h1)
    else $error("capability version wrong");

  nxt_ptr_lock_a: assert property (
    regWr && capSel && cfgLocked && hotRst_n |=> next_capability_pointer_ff == $past(next_capability_pointer_ff))
    else $error("next pointer changed while locked");

  obsolete_bit_a: assert property (
    !stsVec[0] && !clrVec[0] |=> !stsVec[0])
    else $error("obsolete bit set by hardware");

  link_err_set_a: assert property (
    linkProtocolErrDet |=> stsVec[4] && uncorStatus_ff[4] == $past(stsVec[4]))
    else $error("link protocol error not logged");

  surp_gate_a: assert property (
    !stsVec[5] && !surpriseDownReportCapable |=> !stsVec[5])
    else $error("surprise down logged without capability");

  cpl_zero_a: assert property (
    regRd && stsSel |=> regRdData_ff[15:14] == 2'b00)
    else $error("completion timeout or abort read nonzero");

  acs_abort_a: assert property (
    cplAbortForAcs |=> stsVec[21] && !stsVec[15])
    else $error("abort not logged as access violation");

  mc_gate_a: assert property (
    !stsVec[23] && !(multicastBlockEvery || multicastBlockRawAddr) |=> !stsVec[23])
    else $error("multicast blocked logged without control");

  mask_status_a: assert property (
    poisonedDet && maskVec_ff[12] |=> stsVec[12])
    else $error("masked error did not set status");

  mask_report_a: assert property (
    unmaskedEvt == '0 ##1 1'b1 |-> !errReport_ff)
    else $error("report raised for masked error");

  w1c_clear_a: assert property (
    stsWr && regWrData[13] && !flowCtrlErrDet |=> !stsVec[13])
    else $error("write one did not clear");

  w0_keep_a: assert property (
    stsWr && !regWrData[13] && stsVec[13] |=> stsVec[13])
    else $error("write zero cleared a flag");

  hot_keep_a: assert property (
    !hotRst_n && evtVec == '0 && !stsWr |=> stsVec == $past(stsVec))
    else $error("sticky status lost on hot reset");

  rsvd_zero_a: assert property (
    regRd && stsSel |=> (regRdData_ff & ~UES_STS_IMPL) == '0)
    else $error("reserved status bits read nonzero");

  poison_set_a: assert property (
    poisonedDet |=> stsVec[UES_B_POISONED])
    else $error("poisoned packet not logged");

  flow_err_set_a: assert property (
    flowCtrlErrDet |=> stsVec[UES_B_FLOW_CTRL])
    else $error("flow control error not logged");

  unexp_cpl_set_a: assert property (
    unexpCplDet |=> stsVec[UES_B_UNEXP_CPL])
    else $error("unexpected completion not logged");

  rx_ovfl_set_a: assert property (
    rxOverflowDet |=> stsVec[UES_B_RX_OVFL])
    else $error("receive overflow not logged");

  malformed_set_a: assert property (
    malformedDet |=> stsVec[UES_B_MALFORMED])
    else $error("malformed packet not logged");

  ecrc_set_a: assert property (
    ecrcErrDet |=> stsVec[UES_B_ECRC])
    else $error("end-to-end crc failure not logged");

  unsup_req_set_a: assert property (
    unsupReqDet |=> stsVec[UES_B_UNSUP_REQ])
    else $error("unsupported request not logged");

  acs_viol_set_a: assert property (
    acsViolDet |=> stsVec[UES_B_ACS_VIOL])
    else $error("access control violation not logged");

  int_err_set_a: assert property (
    internalErrDet |=> stsVec[UES_B_INT_ERR])
    else $error("internal error not logged");

  mc_block_set_a: assert property (
    mcastBlockedDet && (multicastBlockEvery || multicastBlockRawAddr) |=> stsVec[UES_B_MC_BLOCK])
    else $error("blocked multicast not logged");

  report_raise_a: assert property (
    unmaskedEvt != '0 && hotRst_n |=> errReport_ff)
    else $error("unmasked error not reported");

endmodule : ues_status_bank

// ==== ues_pkg.sv ====
// constants for the uncorrectable error status register bank
package ues_pkg;

  localparam int          UES_ADDR_W       = 12;
  localparam int          UES_DATA_W       = 32;
  localparam int          UES_PTR_W        = 5;

  // register byte offsets
  localparam logic [11:0] UES_OFF_CAP_HDR  = 12'h100;
  localparam logic [11:0] UES_OFF_STATUS   = 12'h104;
  localparam logic [11:0] UES_OFF_MASK     = 12'h108;

  // capability header fields
  localparam int          UES_CAPABILITY_IDENTIFIER_LSB    = 0;
  localparam int          UES_CAPABILITY_VERSION_FIELD_LSB   = 16;
  localparam int          UES_NEXT_CAPABILITY_POINTER_LSB   = 20;
  localparam logic [15:0] UES_CAPABILITY_IDENTIFIER_VAL    = 16'h0001;
  localparam logic [3:0]  UES_CAPABILITY_VERSION_FIELD_VAL   = 4'h1;
  localparam logic [11:0] UES_NEXT_CAPABILITY_POINTER_RST   = 12'h000;

  // status bit positions
  localparam int          UES_B_OBSOLETE   = 0;
  localparam int          UES_B_LINK_PROT  = 4;
  localparam int          UES_B_SURP_DOWN  = 5;
  localparam int          UES_B_POISONED   = 12;
  localparam int          UES_B_FLOW_CTRL  = 13;
  localparam int          UES_B_CPL_TMO    = 14;
  localparam int          UES_B_CPL_ABORT  = 15;
  localparam int          UES_B_UNEXP_CPL  = 16;
  localparam int          UES_B_RX_OVFL    = 17;
  localparam int          UES_B_MALFORMED  = 18;
  localparam int          UES_B_ECRC       = 19;
  localparam int          UES_B_UNSUP_REQ  = 20;
  localparam int          UES_B_ACS_VIOL   = 21;
  localparam int          UES_B_INT_ERR    = 22;
  localparam int          UES_B_MC_BLOCK   = 23;

  // bits that hold a sticky write-one-to-clear flag (also the writable mask bits)
  localparam logic [31:0] UES_STS_IMPL     = 32'h00FF_3031;
  localparam logic [31:0] UES_STS_RST      = 32'h0000_0000;
  localparam logic [31:0] UES_MASK_RST     = 32'h0000_0000;

endpackage : ues_pkg

// ==== ues_sticky_cell.sv ====
// one sticky write-one-to-clear status flag
`timescale 1ns/1ps
module ues_sticky_cell
  import ues_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic setEvt,
  input  wire logic clrReq,
  output logic      flag_ff
);

  logic nxt_flag;

  // set beats a clear arriving in the same cycle
  always_comb
  begin
    nxt_flag = (flag_ff & ~clrReq) | setEvt;
  end

  // only cold reset clears; hot reset is not wired here
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      flag_ff <= 1'b0;
    else
      flag_ff <= nxt_flag;
  end

  clr_wins_not_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    setEvt |=> flag_ff) else $error("flag lost on coincident set");

endmodule : ues_sticky_cell

// ==== tb_ues_status_bank.sv ====
// self-checking testbench for the uncorrectable error status register bank
`timescale 1ns/1ps
module tb_ues_status_bank
  import ues_pkg::*;
();
  logic                  ref_clk;
  logic                  rst_n;
  logic                  hotRst_n;
  logic [UES_ADDR_W-1:0] regAddr;
  logic [UES_DATA_W-1:0] regWrData;
  logic                  regWr;
  logic                  regRd;
  logic [UES_DATA_W-1:0] regRdData_ff;
  logic                  cfgLocked;
  logic                  sdCap;
  logic                  mcEvery;
  logic                  mcRaw;
  logic [12:0]           det;
  logic                  errReport_ff;
  logic                  firstErrValid_ff;
  logic [UES_PTR_W-1:0]  firstErrPtr_ff;
  logic [UES_DATA_W-1:0] uncorStatus_ff;
  int                    miscompares = 0;
  int                    compares = 0;
  int                    cycles = 0;
  int                    bitOf [13] = '{UES_B_LINK_PROT, UES_B_SURP_DOWN, UES_B_POISONED, UES_B_FLOW_CTRL,
                                        UES_B_UNEXP_CPL, UES_B_RX_OVFL, UES_B_MALFORMED, UES_B_ECRC,
                                        UES_B_UNSUP_REQ, UES_B_ACS_VIOL, UES_B_ACS_VIOL, UES_B_INT_ERR,
                                        UES_B_MC_BLOCK};

  ues_status_bank dut (
    .ref_clk, .rst_n, .hotRst_n, .regAddr, .regWrData, .regWr, .regRd, .regRdData_ff, .cfgLocked,
    .surpriseDownReportCapable(sdCap), .multicastBlockEvery(mcEvery), .multicastBlockRawAddr(mcRaw),
    .linkProtocolErrDet(det[0]), .surpriseDownDet(det[1]), .poisonedDet(det[2]), .flowCtrlErrDet(det[3]),
    .unexpCplDet(det[4]), .rxOverflowDet(det[5]), .malformedDet(det[6]), .ecrcErrDet(det[7]),
    .unsupReqDet(det[8]), .acsViolDet(det[9]), .cplAbortForAcs(det[10]), .internalErrDet(det[11]),
    .mcastBlockedDet(det[12]), .errReport_ff, .firstErrValid_ff, .firstErrPtr_ff, .uncorStatus_ff
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: got 0x%h expected 0x%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    chk(regRdData_ff, exp);
    @(posedge ref_clk);
  endtask : rd

  task automatic pulse(input int i, input logic expRep);
    det[i] <= 1'b1;
    @(posedge ref_clk);
    det[i] <= 1'b0;
    #1;
    chk(32'(errReport_ff), 32'(expRep));
    @(posedge ref_clk);
  endtask : pulse

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end

  initial
  begin
    rst_n     = 1'b0;
    hotRst_n  = 1'b1;
    regAddr   = 12'h000;
    regWrData = 32'h0;
    regWr     = 1'b0;
    regRd     = 1'b0;
    cfgLocked = 1'b0;
    sdCap     = 1'b0;
    mcEvery   = 1'b0;
    mcRaw     = 1'b0;
    det       = 13'h0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(UES_OFF_CAP_HDR, 32'h0001_0001);
    #1;
    chk(regRdData_ff, 32'h0);
    @(posedge ref_clk);
    rd(UES_OFF_STATUS, 32'h0);
    rd(12'h10C, 32'h0);
    wr(UES_OFF_STATUS, 32'hFFFF_FFFF);
    rd(UES_OFF_STATUS, 32'h0);
    $display("test reset_values done");
    wr(UES_OFF_CAP_HDR, 32'hFFFF_FFFF);
    rd(UES_OFF_CAP_HDR, 32'hFFF1_0001);
    cfgLocked <= 1'b1;
    wr(UES_OFF_CAP_HDR, 32'h1230_0000);
    rd(UES_OFF_CAP_HDR, 32'hFFF1_0001);
    cfgLocked <= 1'b0;
    wr(UES_OFF_CAP_HDR, 32'h0);
    rd(UES_OFF_CAP_HDR, 32'h0001_0001);
    $display("test next_pointer done");
    sdCap   <= 1'b1;
    mcEvery <= 1'b1;
    for (int i = 0; i < 13; i++)
    begin
      pulse(i, 1'b1);
      chk(32'(firstErrPtr_ff), 32'(bitOf[i]));
      rd(UES_OFF_STATUS, 32'h1 << bitOf[i]);
      wr(UES_OFF_STATUS, 32'h0);
      rd(UES_OFF_STATUS, 32'h1 << bitOf[i]);
      wr(UES_OFF_STATUS, 32'h1 << bitOf[i]);
      rd(UES_OFF_STATUS, 32'h0);
    end
    $display("test detect_sources done");
    sdCap   <= 1'b0;
    mcEvery <= 1'b0;
    pulse(1, 1'b0);
    pulse(12, 1'b0);
    rd(UES_OFF_STATUS, 32'h0);
    mcRaw <= 1'b1;
    pulse(12, 1'b1);
    rd(UES_OFF_STATUS, 32'h0080_0000);
    mcRaw <= 1'b0;
    wr(UES_OFF_STATUS, 32'hFFFF_FFFF);
    $display("test qualified_sources done");
    // detection and clear on the same edge
    pulse(2, 1'b1);
    det[2]    <= 1'b1;
    regAddr   <= UES_OFF_STATUS;
    regWrData <= 32'h0000_1000;
    regWr     <= 1'b1;
    @(posedge ref_clk);
    det[2] <= 1'b0;
    regWr  <= 1'b0;
    @(posedge ref_clk);
    rd(UES_OFF_STATUS, 32'h0000_1000);
    wr(UES_OFF_STATUS, 32'hFFFF_FFFF);
    $display("test set_beats_clear done");
    wr(UES_OFF_MASK, 32'hFFFF_FFFF);
    rd(UES_OFF_MASK, UES_STS_IMPL);
    pulse(3, 1'b0);
    chk(32'(firstErrValid_ff), 32'h0);
    pulse(2, 1'b0);
    rd(UES_OFF_STATUS, 32'h0000_3000);
    wr(UES_OFF_MASK, 32'h0);
    $display("test mask done");
    wr(UES_OFF_CAP_HDR, 32'hABC0_0000);
    hotRst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    hotRst_n <= 1'b1;
    @(posedge ref_clk);
    rd(UES_OFF_STATUS, 32'h0000_3000);
    chk(uncorStatus_ff, 32'h0000_3000);
    rd(UES_OFF_CAP_HDR, 32'h0001_0001);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(UES_OFF_STATUS, 32'h0);
    $display("test resets done");
    tally_and_finish();
  end
endmodule : tb_ues_status_bank
